/* File: bench/ssd_fifo_status_chk.sv */
// Assertion checker for the byte queues and status register
`timescale 1ns/1ns
`default_nettype none
module ssd_fifo_status_chk
  import ssd_pkg::*;
(
  // Bus domain
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       busEnable,
  input wire logic       regSelect,
  input wire logic       readNotWrite,
  input wire logic [7:0] rdData,
  input wire logic [3:0] dataBits,
  input wire logic       extSyncMode,
  input wire logic       syncFillEnable,
  input wire logic [7:0] syncCode,
  input wire logic       txSoftReset,
  input wire logic       rxIntEnable,
  input wire logic       txIntEnable,
  input wire logic       errorIntEnable,
  input wire logic       carrierDetect,
  input wire logic       ctsLine,
  input wire logic       irqN,
  // Link domain
  input wire logic       lnkClk,
  input wire logic [7:0] txChar,
  input wire logic       txCharValid,
  input wire logic       txUnderflowPulse
);
  sequence s_stat_rd;
    busEnable && !regSelect && readNotWrite;
  endsequence
  sequence s_rx_rd;
    busEnable && regSelect && readNotWrite && dataBits >= SSD_BITS_MIN && dataBits <= SSD_BITS_MAX;
  endsequence
  // Pins cross two synchroniser flops, so six cycles of level is ample
  sequence s_cts_held;
    (ctsLine && !extSyncMode) [*6];
  endsequence
  a_irq_bit_mirror: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_stat_rd |=> rdData[ST_IRQ] == !$past(irqN)) else $error("irq status bit mismatch");
  a_irq_all_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rxIntEnable && !txIntEnable && !errorIntEnable |=> irqN) else $error("irq without enable");
  a_read_no_side: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(busEnable && readNotWrite) |=> $stable(rdData)) else $error("read data moved");
  a_rx_zero_pad: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_rd |=> (rdData >> $past(dataBits)) == 8'h00) else $error("unused bits not zero");
  a_cts_no_space: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_cts_held ##0 s_stat_rd |=> !rdData[ST_TX_SPACE]) else $error("space flag under cts");
  a_rst_no_space: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txSoftReset [*3] ##0 s_stat_rd |=> !rdData[ST_TX_SPACE]) else $error("space flag in reset");
  a_cts_bit_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctsLine [*6] ##0 s_stat_rd |=> rdData[ST_CTS]) else $error("cts status low");
  a_dcd_bit_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    carrierDetect [*6] ##0 s_stat_rd |=> rdData[ST_CARRIER]) else $error("carrier status low");
  a_fill_sync_code: assert property (@(posedge lnkClk) disable iff (!rst_n)
    txUnderflowPulse |-> txCharValid && syncFillEnable && txChar == syncCode)
    else $error("underflow pulse without sync fill");
  a_valid_one_cyc: assert property (@(posedge lnkClk) disable iff (!rst_n)
    txCharValid |=> !txCharValid) else $error("valid longer than one cycle");
endmodule
bind ssd_fifo_status ssd_fifo_status_chk i_ssd_fifo_status_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .busEnable(busEnable), .regSelect(regSelect),
  .readNotWrite(readNotWrite), .rdData(rdData), .dataBits(dataBits),
  .extSyncMode(extSyncMode), .syncFillEnable(syncFillEnable), .syncCode(syncCode),
  .txSoftReset(txSoftReset), .rxIntEnable(rxIntEnable), .txIntEnable(txIntEnable),
  .errorIntEnable(errorIntEnable), .carrierDetect(carrierDetect), .ctsLine(ctsLine),
  .irqN(irqN), .lnkClk(lnkClk), .txChar(txChar), .txCharValid(txCharValid),
  .txUnderflowPulse(txUnderflowPulse));
`default_nettype wire

/* File: bench/ssd_fifo_status_test.sv */
// Testbench for the byte queues and status register
`timescale 1ns/1ns
`default_nettype none
module ssd_fifo_status_test;
  import ssd_pkg::*;
  logic       sys_clk, rst_n, lnkClk, busEnable, regSelect, readNotWrite, txQueueSelect;
  logic       oneByteMode, parityEnable, parityOdd, syncFillEnable, extSyncMode;
  logic       rxSoftReset, txSoftReset, clearCtsCmd, clearUnderflowCmd;
  logic       rxIntEnable, txIntEnable, errorIntEnable, carrierDetect, ctsLine, irqN;
  logic       rxCharStrobe, rxParityBad, txCharReq, txParityBit, txCharValid, txUnderflowPulse;
  logic [3:0] dataBits;
  logic [7:0] wrData, rdData, syncCode, rxChar, txChar, st, rd;
  int         errCount, testsRun;
  ssd_fifo_status i_ssd_fifo_status (
    .sys_clk(sys_clk), .rst_n(rst_n), .busEnable(busEnable), .regSelect(regSelect),
    .readNotWrite(readNotWrite), .txQueueSelect(txQueueSelect), .wrData(wrData),
    .rdData(rdData), .oneByteMode(oneByteMode), .dataBits(dataBits),
    .parityEnable(parityEnable), .parityOdd(parityOdd), .syncFillEnable(syncFillEnable),
    .extSyncMode(extSyncMode), .syncCode(syncCode), .rxSoftReset(rxSoftReset),
    .txSoftReset(txSoftReset), .clearCtsCmd(clearCtsCmd), .clearUnderflowCmd(clearUnderflowCmd),
    .rxIntEnable(rxIntEnable), .txIntEnable(txIntEnable), .errorIntEnable(errorIntEnable),
    .carrierDetect(carrierDetect), .ctsLine(ctsLine), .irqN(irqN), .lnkClk(lnkClk),
    .rxCharStrobe(rxCharStrobe), .rxChar(rxChar), .rxParityBad(rxParityBad),
    .txCharReq(txCharReq), .txChar(txChar), .txParityBit(txParityBit),
    .txCharValid(txCharValid), .txUnderflowPulse(txUnderflowPulse));
  ssd_link_model i_ssd_link_model (
    .lnkClk(lnkClk), .rxCharStrobe(rxCharStrobe), .rxChar(rxChar), .rxParityBad(rxParityBad),
    .txCharReq(txCharReq), .txChar(txChar), .txParityBit(txParityBit),
    .txCharValid(txCharValid), .txUnderflowPulse(txUnderflowPulse));
  always #4 sys_clk = ~sys_clk;
  always #16 lnkClk = ~lnkClk;
  task automatic closeOut();
    if (errCount == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Every access is three cycles, which leaves the shift pulse between reads or writes
  task automatic bus(input logic rs, input logic rw, input logic ts, input logic [7:0] wd);
    @(negedge sys_clk);
    {regSelect, readNotWrite, txQueueSelect, wrData, busEnable} = {rs, rw, ts, wd, 1'b1};
    @(negedge sys_clk);
    busEnable = 1'b0;
    @(negedge sys_clk);
    rd = rdData;
  endtask
  task automatic stat();
    bus(1'b0, 1'b1, 1'b0, 8'h00);
    st = rd;
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pullChk(input logic [7:0] c, input logic p, input logic uf);
    logic [7:0] gc;
    logic       gp, gu, ok;
    i_ssd_link_model.pull(gc, gp, gu, ok);
    if (!ok) begin
      errCount++;
      closeOut();
    end else begin
      chk(gc, c);
      chk({7'h0, gp}, {7'h0, p});
      chk({7'h0, gu}, {7'h0, uf});
    end
  endtask
  task automatic s_reset();
    chk(rdData, SSD_RD_RESET);
    chk(txChar, SSD_MARK_FILL);
    chk({7'h0, irqN}, 8'h01);
  endtask
  task automatic s_rx();
    logic [7:0] q [5];
    q = '{8'h31, 8'h52, 8'h73, 8'h94, 8'hb5};
    rxSoftReset = 1'b1;
    hold(3);
    rxSoftReset = 1'b0;
    for (int i = 0; i < 5; i++) begin
      i_ssd_link_model.send(q[i], i == 0);
      repeat (3) stat();
    end
    chk({7'h0, st[ST_OVERRUN]}, 8'h01);
    chk({7'h0, st[ST_PARITY]}, 8'h01);
    chk({7'h0, st[ST_RX_READY]}, 8'h01);
    stat();
    chk({7'h0, st[ST_OVERRUN]}, 8'h01);
    bus(1'b1, 1'b1, 1'b0, 8'h00);
    chk(rd, q[0]);
    stat();
    chk({7'h0, st[ST_OVERRUN]}, 8'h00);
    chk({7'h0, st[ST_PARITY]}, 8'h00);
    dataBits = 4'h5;
    bus(1'b1, 1'b1, 1'b0, 8'h00);
    chk(rd, q[1] & 8'h1f);
    dataBits = 4'h8;
    oneByteMode = 1'b0;
    stat();
    chk({7'h0, st[ST_RX_READY]}, 8'h00);
    oneByteMode = 1'b1;
    stat();
    chk({7'h0, st[ST_RX_READY]}, 8'h01);
    bus(1'b1, 1'b1, 1'b0, 8'h00);
    chk(rd, q[4]);
  endtask
  task automatic s_dcd();
    carrierDetect = 1'b1;
    hold(8);
    stat();
    chk({7'h0, st[ST_CARRIER]}, 8'h01);
    carrierDetect = 1'b0;
    hold(8);
    stat();
    chk({7'h0, st[ST_CARRIER]}, 8'h01);
    bus(1'b1, 1'b1, 1'b0, 8'h00);
    chk(rd, 8'h00);
    stat();
    chk({7'h0, st[ST_CARRIER]}, 8'h00);
  endtask
  task automatic s_tx();
    logic [7:0] t [3];
    t = '{8'h5a, 8'hc1, 8'h07};
    parityOdd = 1'b1;
    txSoftReset = 1'b1;
    hold(4);
    stat();
    chk({7'h0, st[ST_TX_SPACE]}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 1'b0, 1'b1, t[i]);
      stat();
    end
    stat();
    chk({7'h0, st[ST_TX_SPACE]}, 8'h00);
    txSoftReset = 1'b0;
    repeat (2) stat();
    for (int i = 0; i < 3; i++) begin
      pullChk(t[i], ~^t[i], 1'b0);
      repeat (2) stat();
    end
    chk({7'h0, st[ST_TX_SPACE]}, 8'h01);
    pullChk(syncCode, ~^syncCode, 1'b1);
    stat();
    chk({7'h0, st[ST_UNDERFLOW]}, 8'h01);
    clearUnderflowCmd = 1'b1;
    hold(2);
    clearUnderflowCmd = 1'b0;
    syncFillEnable = 1'b0;
    pullChk(SSD_MARK_FILL, 1'b1, 1'b0);
    stat();
    chk({7'h0, st[ST_UNDERFLOW]}, 8'h00);
  endtask
  task automatic s_cts();
    errorIntEnable = 1'b1;
    ctsLine = 1'b1;
    hold(8);
    stat();
    chk({7'h0, st[ST_TX_SPACE]}, 8'h00);
    chk({7'h0, st[ST_IRQ]}, 8'h01);
    extSyncMode = 1'b1;
    hold(6);
    stat();
    chk({7'h0, st[ST_TX_SPACE]}, 8'h01);
    ctsLine = 1'b0;
    hold(8);
    stat();
    chk({7'h0, st[ST_CTS]}, 8'h01);
    clearCtsCmd = 1'b1;
    hold(2);
    clearCtsCmd = 1'b0;
    stat();
    chk({7'h0, st[ST_CTS]}, 8'h00);
    chk({7'h0, irqN}, 8'h01);
  endtask
  initial begin
    {sys_clk, lnkClk, rst_n, busEnable, regSelect, readNotWrite, txQueueSelect} = '0;
    {parityOdd, extSyncMode, rxSoftReset, txSoftReset, clearCtsCmd, clearUnderflowCmd} = '0;
    {rxIntEnable, txIntEnable, errorIntEnable, carrierDetect, ctsLine} = '0;
    {oneByteMode, parityEnable, syncFillEnable} = 3'b111;
    {dataBits, wrData, syncCode, errCount, testsRun} = {4'h8, 8'h00, 8'h3c, 64'h0};
    hold(16);
    rst_n = 1'b1;
    hold(3);
    s_reset();
    s_rx();
    s_dcd();
    s_tx();
    s_cts();
    closeOut();
  end
endmodule
`default_nettype wire

/* File: bench/ssd_link_model.sv */
// Serial engine model on the link clock
`timescale 1ns/1ns
`default_nettype none
module ssd_link_model (
  // Link clock
  input  wire logic       lnkClk,
  // Receive side
  output logic            rxCharStrobe,
  output logic      [7:0] rxChar,
  output logic            rxParityBad,
  // Transmit side
  output logic            txCharReq,
  input  wire logic [7:0] txChar,
  input  wire logic       txParityBit,
  input  wire logic       txCharValid,
  input  wire logic       txUnderflowPulse
);
  initial begin
    rxCharStrobe = 1'b0;
    rxChar       = 8'h00;
    rxParityBad  = 1'b0;
    txCharReq    = 1'b0;
  end
  // Data lines flip after the strobe so a late sample cannot look right
  task automatic send(input logic [7:0] c, input logic bad);
    @(posedge lnkClk);
    rxChar       <= c;
    rxParityBad  <= bad;
    rxCharStrobe <= 1'b1;
    @(posedge lnkClk);
    rxCharStrobe <= 1'b0;
    rxChar       <= ~c;
    rxParityBad  <= ~bad;
    repeat (5) @(posedge lnkClk);
  endtask
  // One request, then wait for the answer before any other
  task automatic pull(output logic [7:0] c, output logic p, output logic uf, output logic ok);
    ok = 1'b0;
    @(posedge lnkClk);
    txCharReq <= 1'b1;
    @(posedge lnkClk);
    txCharReq <= 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(negedge lnkClk);
      if (txCharValid === 1'b1) begin
        ok = 1'b1;
        c  = txChar;
        p  = txParityBit;
        uf = txUnderflowPulse;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: hw/ssd_byte_chain.sv */
// Shift-chain FIFO: stages with own full flags, advancing on enable pulses
`timescale 1ns/1ns
`default_nettype none
module ssd_byte_chain #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             shift,
  input  wire logic             pop,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             flush,
  // State
  output logic      [DEPTH-1:0] full,
  output logic      [WIDTH-1:0] headData,
  output logic                  overwrite
);
  logic [DEPTH-1:0] fullQ;
  logic [DEPTH-1:0] fullD;
  logic [WIDTH-1:0] dataQ [DEPTH];
  logic [WIDTH-1:0] dataD [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("ssd_byte_chain needs DEPTH >= 2 and WIDTH >= 1");
  end

  // A byte moves only from a full stage into the next empty one, one place per pulse
  always_comb begin
    fullD     = fullQ;
    dataD     = dataQ;
    overwrite = 1'b0;
    if (pop) begin
      fullD[DEPTH-1] = 1'b0;
    end
    if (shift) begin
      for (int i = DEPTH - 2; i >= 0; i--) begin
        if (fullD[i] && !fullD[i+1]) begin
          dataD[i+1] = dataD[i];
          fullD[i+1] = 1'b1;
          fullD[i]   = 1'b0;
        end
      end
    end
    // Full first stage is overwritten, older bytes further on survive
    if (push) begin
      overwrite = fullD[0];
      dataD[0]  = pushData;
      fullD[0]  = 1'b1;
    end
    if (flush) begin
      fullD = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fullQ <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        dataQ[i] <= '0;
      end
    end else begin
      fullQ <= fullD;
      dataQ <= dataD;
    end
  end

  assign full     = fullQ;
  assign headData = dataQ[DEPTH-1];
endmodule
`default_nettype wire

/* File: hw/ssd_fifo_status.sv */
// Receive and transmit byte queues with the channel status register
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Receive queue: three stages, shift on enable
// - Overrun overwrites the first receive stage
// - Overrun flag cleared by status-then-data read
// - Unused receive data bits read as zero
// - Transmit queue: three stages, shift on enable
// - Unused transmit bits ignored, parity generated here
// - Underflow sends fill; latches, pulses output in sync-fill mode
// - Status is read-only, reading clears nothing
// - Data-ready: stage three, or two and three
// - Space-ready: stage one, or one and two empty
// - Tx soft reset inhibits space flag; soft resets empty
// - CTS inhibits space flag unless external sync
// - Carrier bit latches rise, then follows input
// - CTS bit latches rise, then follows input
// - Underflow bit set in sync-fill mode only
// - Parity bit tracks last receive stage byte
// - Status bit seven mirrors interrupt output
// - Control bit picks one- or two-byte readiness
module ssd_fifo_status
  import ssd_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Host bus, sampled while busEnable is high
  input  wire logic       busEnable,
  input  wire logic       regSelect,
  input  wire logic       readNotWrite,
  input  wire logic       txQueueSelect,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  // Settings from the control register logic
  input  wire logic       oneByteMode,
  input  wire logic [3:0] dataBits,
  input  wire logic       parityEnable,
  input  wire logic       parityOdd,
  input  wire logic       syncFillEnable,
  input  wire logic       extSyncMode,
  input  wire logic [7:0] syncCode,
  input  wire logic       rxSoftReset,
  input  wire logic       txSoftReset,
  input  wire logic       clearCtsCmd,
  input  wire logic       clearUnderflowCmd,
  input  wire logic       rxIntEnable,
  input  wire logic       txIntEnable,
  input  wire logic       errorIntEnable,
  // Modem lines
  input  wire logic       carrierDetect,
  input  wire logic       ctsLine,
  // Interrupt
  output logic            irqN,
  // Serial engine side, on the link clock
  input  wire logic       lnkClk,
  input  wire logic       rxCharStrobe,
  input  wire logic [7:0] rxChar,
  input  wire logic       rxParityBad,
  input  wire logic       txCharReq,
  output logic      [7:0] txChar,
  output logic            txParityBit,
  output logic            txCharValid,
  output logic            txUnderflowPulse
);

  function automatic logic [7:0] charMask(input logic [3:0] bits);
    logic [3:0] b;
    b = bits;
    if (b > SSD_BITS_MAX) b = SSD_BITS_MAX;
    if (b < SSD_BITS_MIN) b = SSD_BITS_MIN;
    return 8'hff >> (SSD_BITS_MAX - b);
  endfunction
  function automatic logic parityOf(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction
  // Bus decode
  logic statusRead;
  logic rxRead;
  logic txWrite;
  assign statusRead = busEnable && !regSelect && readNotWrite;
  assign rxRead     = busEnable && regSelect && readNotWrite;
  assign txWrite    = busEnable && regSelect && !readNotWrite && txQueueSelect;
  // Link domain: receive capture
  logic [8:0] rxHoldQ;
  logic       rxTglQ;

  // Held word is stable for the whole crossing; engine delivers whole characters
  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      rxHoldQ <= '0;
      rxTglQ  <= 1'b0;
    end else if (rxCharStrobe) begin
      rxHoldQ <= {rxParityBad, rxChar};
      rxTglQ  <= ~rxTglQ;
    end
  end
  // Link domain: transmit request
  logic txReqTglQ;
  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      txReqTglQ <= 1'b0;
    end else if (txCharReq) begin
      txReqTglQ <= ~txReqTglQ;
    end
  end
  // Crossings into the bus domain
  logic rxTglS;
  logic txReqTglS;
  logic carrierS;
  logic ctsS;

  ssd_sync2 #(.W(4)) uSyncSys (
    .clk  (sys_clk),
    .rst_n(rst_n),
    .din  ({rxTglQ, txReqTglQ, carrierDetect, ctsLine}),
    .dout ({rxTglS, txReqTglS, carrierS, ctsS})
  );

  logic rxTglSeenQ;
  logic txReqSeenQ;
  logic carrierPrevQ;
  logic ctsPrevQ;
  logic rxEvent;
  logic txEvent;
  assign rxEvent = rxTglS ^ rxTglSeenQ;
  assign txEvent = txReqTglS ^ txReqSeenQ;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxTglSeenQ   <= 1'b0;
      txReqSeenQ   <= 1'b0;
      carrierPrevQ <= 1'b0;
      ctsPrevQ     <= 1'b0;
    end else begin
      rxTglSeenQ   <= rxTglS;
      txReqSeenQ   <= txReqTglS;
      carrierPrevQ <= carrierS;
      ctsPrevQ     <= ctsS;
    end
  end
  // Receive queue
  logic [2:0] rxFull;
  logic [8:0] rxHead;
  logic       rxOverwrite;
  logic       rxPush;
  assign rxPush = rxEvent && !rxSoftReset;

  ssd_byte_chain #(.WIDTH(SSD_BYTE_W + 1), .DEPTH(SSD_STAGES)) uRxChain (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .shift    (busEnable),
    .pop      (rxRead && rxFull[SSD_STAGES-1]),
    .push     (rxPush),
    .pushData (rxHoldQ),
    .flush    (rxSoftReset),
    .full     (rxFull),
    .headData (rxHead),
    .overwrite(rxOverwrite)
  );
  // Transmit queue
  logic [2:0] txFull;
  logic [7:0] txHead;
  logic       txPop;
  logic       txSrPrevQ;
  logic       txHoldQ;

  // Tx soft reset empties the queue on its rise; loading reopens at the next enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txSrPrevQ <= 1'b0;
      txHoldQ   <= 1'b0;
    end else begin
      txSrPrevQ <= txSoftReset;
      if (txSoftReset && !txSrPrevQ) begin
        txHoldQ <= 1'b1;
      end else if (busEnable) begin
        txHoldQ <= 1'b0;
      end
    end
  end

  assign txPop = txEvent && !txSoftReset && txFull[SSD_STAGES-1];

  ssd_byte_chain #(.WIDTH(SSD_BYTE_W), .DEPTH(SSD_STAGES)) uTxChain (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .shift    (busEnable),
    .pop      (txPop),
    .push     (txWrite && !txHoldQ),
    .pushData (wrData & charMask(dataBits)),
    .flush    (txHoldQ),
    .full     (txFull),
    .headData (txHead),
    .overwrite()
  );
  // Status flags
  logic rxReady;
  logic txSpace;
  logic readArmQ;
  logic carrierLatchQ;
  logic ctsLatchQ;
  logic underflowQ;
  logic overrunQ;
  logic parityFlag;
  logic statusClear;
  logic underflowSet;
  logic irqNQ;

  assign rxReady = oneByteMode ? rxFull[2] : (rxFull[2] && rxFull[1]);
  // CTS gates the flag only, never the queue contents
  assign txSpace = !txSoftReset && !(ctsS && !extSyncMode)
                   && (oneByteMode ? !txFull[0] : (!txFull[0] && !txFull[1]));
  assign parityFlag = rxFull[2] && rxHead[SSD_BYTE_W];
  assign statusClear = rxRead && readArmQ;
  assign underflowSet = txEvent && !txSoftReset && !txFull[SSD_STAGES-1] && syncFillEnable;

  // A status read arms the clear; the following data read fires it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      readArmQ <= 1'b0;
    end else if (statusRead || rxSoftReset) begin
      readArmQ <= statusRead;
    end else if (rxRead) begin
      readArmQ <= 1'b0;
    end
  end

  // Set wins over clear in every latch below
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrunQ <= 1'b0;
    end else if (rxOverwrite) begin
      overrunQ <= 1'b1;
    end else if (statusClear || rxSoftReset) begin
      overrunQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carrierLatchQ <= 1'b0;
    end else if (carrierS && !carrierPrevQ) begin
      carrierLatchQ <= 1'b1;
    end else if (statusClear || rxSoftReset) begin
      carrierLatchQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctsLatchQ <= 1'b0;
    end else if (ctsS && !ctsPrevQ) begin
      ctsLatchQ <= 1'b1;
    end else if (clearCtsCmd || txSoftReset) begin
      ctsLatchQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      underflowQ <= 1'b0;
    end else if (underflowSet) begin
      underflowQ <= 1'b1;
    end else if (clearUnderflowCmd || txSoftReset) begin
      underflowQ <= 1'b0;
    end
  end

  // Interrupt output and status bit seven share one flop, so they never disagree
  logic errorAny;
  assign errorAny = overrunQ || carrierLatchQ || parityFlag || ctsLatchQ || underflowQ;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqNQ <= 1'b1;
    end else begin
      irqNQ <= !((rxIntEnable && rxReady) || (txIntEnable && txSpace)
                 || (errorIntEnable && errorAny));
    end
  end
  assign irqN = irqNQ;

  logic [7:0] statusWord;
  always_comb begin
    statusWord               = '0;
    statusWord[ST_RX_READY]  = rxReady;
    statusWord[ST_TX_SPACE]  = txSpace;
    statusWord[ST_CARRIER]   = carrierLatchQ || carrierS;
    statusWord[ST_CTS]       = ctsLatchQ || ctsS;
    statusWord[ST_UNDERFLOW] = underflowQ;
    statusWord[ST_OVERRUN]   = overrunQ;
    statusWord[ST_PARITY]    = parityFlag;
    statusWord[ST_IRQ]       = !irqNQ;
  end

  // Read data holds until the next read; status reads clear no flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= SSD_RD_RESET;
    end else if (statusRead) begin
      rdData <= statusWord;
    end else if (rxRead) begin
      rdData <= rxFull[2] ? (rxHead[7:0] & charMask(dataBits)) : '0;
    end
  end
  // Transmit character hand-off
  logic [9:0] txWordQ;
  logic       txAckTglQ;
  logic [7:0] fillChar;
  logic       fillParity;
  logic [7:0] sendChar;

  assign sendChar   = txHead & charMask(dataBits);
  assign fillChar   = syncFillEnable ? syncCode : SSD_MARK_FILL;
  // Mark fill carries a one in the parity slot too
  assign fillParity = syncFillEnable ? (parityEnable && parityOf(syncCode, parityOdd)) : 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txWordQ   <= '0;
      txAckTglQ <= 1'b0;
    end else if (txEvent) begin
      txAckTglQ <= ~txAckTglQ;
      if (txPop) begin
        txWordQ <= {1'b0, parityEnable && parityOf(sendChar, parityOdd), sendChar};
      end else if (txSoftReset) begin
        txWordQ <= {1'b0, 1'b1, SSD_MARK_FILL};
      end else begin
        txWordQ <= {syncFillEnable, fillParity, fillChar};
      end
    end
  end
  // Link domain: transmit answer
  logic txAckS;
  logic txAckSeenQ;

  ssd_sync2 #(.W(1)) uSyncLnk (
    .clk  (lnkClk),
    .rst_n(rst_n),
    .din  (txAckTglQ),
    .dout (txAckS)
  );

  // Underflow pulse lasts one link clock, a whole period of it, high and low phase
  always_ff @(posedge lnkClk or negedge rst_n) begin
    if (!rst_n) begin
      txAckSeenQ       <= 1'b0;
      txChar           <= SSD_MARK_FILL;
      txParityBit      <= 1'b1;
      txCharValid      <= 1'b0;
      txUnderflowPulse <= 1'b0;
    end else begin
      txAckSeenQ       <= txAckS;
      txCharValid      <= txAckS ^ txAckSeenQ;
      txUnderflowPulse <= (txAckS ^ txAckSeenQ) && txWordQ[9];
      if (txAckS ^ txAckSeenQ) begin
        txChar      <= txWordQ[7:0];
        txParityBit <= txWordQ[8];
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/ssd_sync2.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module ssd_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level in and out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] metaQ;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      metaQ <= '0;
      dout  <= '0;
    end else begin
      metaQ <= din;
      dout  <= metaQ;
    end
  end
endmodule
`default_nettype wire

/* File: shared/ssd_pkg.sv */
// Shared constants for the serial adapter FIFOs and status register
package ssd_pkg;
  localparam int          SSD_STAGES    = 3;
  localparam int          SSD_BYTE_W    = 8;
  // Status register bit positions
  localparam int          ST_RX_READY   = 0;
  localparam int          ST_TX_SPACE   = 1;
  localparam int          ST_CARRIER    = 2;
  localparam int          ST_CTS        = 3;
  localparam int          ST_UNDERFLOW  = 4;
  localparam int          ST_OVERRUN    = 5;
  localparam int          ST_PARITY     = 6;
  localparam int          ST_IRQ        = 7;
  // Reset and fill values, character length limits
  localparam logic [7:0]  SSD_MARK_FILL = 8'hff;
  localparam logic [7:0]  SSD_RD_RESET  = 8'h00;
  localparam logic [3:0]  SSD_BITS_MAX  = 4'h8;
  localparam logic [3:0]  SSD_BITS_MIN  = 4'h5;
endpackage
